/* pkg/fsr_pkg.sv */
// Purpose: constants and types for the fault status / identity register bank
// Assumes: one 40 MHz clock, bus pins sampled synchronously
// Notes:   register map and reset values shared by design and bench
package fsr_pkg;

    localparam logic [6:0] DEV_ADDR      = 7'h38;
    localparam logic [7:0] REG_FUNC1     = 8'h00;
    localparam logic [7:0] REG_FUNC2     = 8'h01;
    localparam logic [7:0] REG_FAULT     = 8'h02;
    localparam logic [7:0] REG_ID        = 8'h03;
    localparam logic [7:0] FUNC1_RESET   = 8'h86;
    localparam logic [7:0] FUNC2_RESET   = 8'h28;
    localparam logic [1:0] PROT_RESET    = 2'h0;
    localparam logic [5:0] FLAGS_RESET   = 6'h00;
    // arbitrary identity value, not tied to any real part
    localparam logic [7:0] ID_CODE       = 8'h5a;
    localparam int         FSW_LSB       = 3;
    localparam int         FSW_MSB       = 4;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam logic [11:0] FSW_KHZ_200  = 12'h0c8;
    localparam logic [11:0] FSW_KHZ_400  = 12'h190;
    localparam logic [11:0] FSW_KHZ_1000 = 12'h3e8;
    localparam logic [11:0] FSW_KHZ_2200 = 12'h898;

    typedef struct packed {
        logic pin_ground_short_flag;
        logic overtemp_flag;
        logic output_undervolt_flag;
        logic overcurrent_flag;
        logic source_short_flag;
        logic source_open_flag;
    } fsr_fault_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } fsr_state_t;

endpackage : fsr_pkg

/* hdl/fsr_regs.sv */
// Purpose: serial-access register bank with latched fault flags and identity
// Assumes: scl/sda already synchronous to clk_sys_i; bus far slower than clock
// Notes:   sda is open drain: sda_oe_n_o low means the pin is pulled low
`timescale 1ns/1ps
module fsr_regs
    import fsr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // serial bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    // protection events
    input  wire fsr_fault_t  fault_evt_i,
    // configuration and fault status to the converter
    output logic [7:0]       func1_o,
    output logic [7:0]       func2_o,
    output logic [1:0]       prot_ctrl_o,
    output logic [1:0]       switch_set_pin_a_select_o,
    output logic [11:0]      switch_set_pin_a_khz_o,
    output fsr_fault_t       fault_flags_o
);

    function automatic logic [11:0] set_pin_a_khz(input logic [1:0] code);
        logic [11:0] r;
        r = FSW_KHZ_200;
        case (code)
            2'h1: r = FSW_KHZ_400;
            2'h2: r = FSW_KHZ_1000;
            2'h3: r = FSW_KHZ_2200;
            default: r = FSW_KHZ_200;
        endcase
        return r;
    endfunction : set_pin_a_khz

    ////////////////////////////////////////////////////////////////////////
    fsr_state_t  state_q;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  ptr_q;
    logic        rw_q;
    logic        drive_q;
    logic        nack_q;
    logic [5:0]  snap_q;
    logic [7:0]  func1_q;
    logic [7:0]  func2_q;
    logic [1:0]  prot_q;
    logic [5:0]  flags_q;
    logic [5:0]  flags_d;
    logic [11:0] khz_q;

    wire scl_rise = scl_i & ~scl_q;
    wire scl_fall = ~scl_i & scl_q;
    wire start_c  = scl_i & scl_q & sda_q & ~sda_i;
    wire stop_c   = scl_i & scl_q & ~sda_q & sda_i;
    wire byte_end = (cnt_q == BYTE_BITS);
    wire addr_hit = (shift_q[7:1] == DEV_ADDR);
    wire [5:0] evt = fault_evt_i;

    // read data mux
    wire [7:0] rd_byte;
    assign rd_byte = (ptr_q == REG_FUNC1) ? func1_q :
                     (ptr_q == REG_FUNC2) ? func2_q :
                     (ptr_q == REG_FAULT) ? {prot_q, flags_q} :
                     (ptr_q == REG_ID)    ? ID_CODE : 8'h00;
    wire [5:0] rd_flags = (ptr_q == REG_FAULT) ? flags_q : 6'h00;

    // clear fires at the master's ack slot, once the byte is fully sent
    wire rd_done = (state_q == ST_RDATA_ACK) && scl_rise;
    wire [5:0] clr_mask = rd_done ? snap_q : 6'h00;
    wire wr_en = (state_q == ST_WDATA) && scl_fall && byte_end;

    // set beats clear, so an event landing on the clear cycle survives
    assign flags_d = (flags_q & ~clr_mask) | evt;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            flags_q <= FLAGS_RESET;
            func1_q <= FUNC1_RESET;
            func2_q <= FUNC2_RESET;
            prot_q  <= PROT_RESET;
            khz_q   <= FSW_KHZ_400;
        end
        else
        begin
            flags_q <= flags_d;
            khz_q   <= set_pin_a_khz(func2_q[FSW_MSB:FSW_LSB]);
            if (wr_en && ptr_q == REG_FUNC1)
                func1_q <= shift_q;
            if (wr_en && ptr_q == REG_FUNC2)
                func2_q <= shift_q;
            if (wr_en && ptr_q == REG_FAULT)
                prot_q <= shift_q[7:6];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            state_q <= ST_IDLE;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            ptr_q   <= 8'h00;
            rw_q    <= 1'b0;
            drive_q <= 1'b0;
            nack_q  <= 1'b0;
            snap_q  <= 6'h00;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            if (stop_c)
            begin
                state_q <= ST_IDLE;
                drive_q <= 1'b0;
            end
            else if (start_c)
            begin
                state_q <= ST_ADDR;
                cnt_q   <= 4'h0;
                drive_q <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (state_q)
                    ST_ADDR, ST_REG, ST_WDATA:
                    begin
                        shift_q <= {shift_q[6:0], sda_i};
                        cnt_q   <= cnt_q + 4'h1;
                    end
                    ST_RDATA:
                    begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        cnt_q   <= cnt_q + 4'h1;
                    end
                    ST_RDATA_ACK:
                    begin
                        nack_q <= sda_i;
                        ptr_q  <= ptr_q + 8'h01;
                    end
                    default: ;
                endcase
            end
            else if (scl_fall)
            begin
                case (state_q)
                    ST_ADDR:
                        if (byte_end)
                        begin
                            if (addr_hit)
                            begin
                                state_q <= ST_ADDR_ACK;
                                rw_q    <= shift_q[0];
                                drive_q <= 1'b1;
                            end
                            else
                                state_q <= ST_IDLE;
                        end
                    ST_ADDR_ACK, ST_RDATA_ACK:
                    begin
                        cnt_q <= 4'h0;
                        if ((state_q == ST_ADDR_ACK && rw_q) ||
                            (state_q == ST_RDATA_ACK && !nack_q))
                        begin
                            state_q <= ST_RDATA;
                            shift_q <= rd_byte;
                            snap_q  <= rd_flags;
                            drive_q <= ~rd_byte[7];
                        end
                        else
                        begin
                            state_q <= (state_q == ST_ADDR_ACK) ?
                                       ST_REG : ST_IDLE;
                            drive_q <= 1'b0;
                        end
                    end
                    ST_REG:
                        if (byte_end)
                        begin
                            state_q <= ST_REG_ACK;
                            ptr_q   <= shift_q;
                            drive_q <= 1'b1;
                        end
                    ST_WDATA:
                        if (byte_end)
                        begin
                            state_q <= ST_WDATA_ACK;
                            drive_q <= 1'b1;
                        end
                    ST_REG_ACK, ST_WDATA_ACK:
                    begin
                        if (state_q == ST_WDATA_ACK)
                            ptr_q <= ptr_q + 8'h01;
                        state_q <= ST_WDATA;
                        cnt_q   <= 4'h0;
                        drive_q <= 1'b0;
                    end
                    ST_RDATA:
                        if (byte_end)
                        begin
                            state_q <= ST_RDATA_ACK;
                            drive_q <= 1'b0;
                        end
                        else
                            drive_q <= ~shift_q[7];
                    default: ;
                endcase
            end
        end
    end

    assign sda_o                = 1'b0;
    assign sda_oe_n_o           = ~drive_q;
    assign func1_o              = func1_q;
    assign func2_o              = func2_q;
    assign prot_ctrl_o          = prot_q;
    assign switch_set_pin_a_select_o = func2_q[FSW_MSB:FSW_LSB];
    assign switch_set_pin_a_khz_o    = khz_q;
    assign fault_flags_o        = flags_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    chk_ground_short_set: assert property (evt[5] |=> flags_q[5])
        else $error("ground short flag not set");
    chk_overtemp_set: assert property (evt[4] |=> flags_q[4])
        else $error("overtemp flag not set");
    chk_undervolt_set: assert property (evt[3] |=> flags_q[3])
        else $error("undervolt flag not set");
    chk_overcurrent_set: assert property (evt[2] |=> flags_q[2])
        else $error("overcurrent flag not set");
    chk_src_short_set: assert property (evt[1] |=> flags_q[1])
        else $error("source short flag not set");
    chk_src_open_set: assert property (evt[0] |=> flags_q[0])
        else $error("source open flag not set");
    chk_flag_holds: assert property (!rd_done |=>
        ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("flag dropped without a read");
    chk_read_clears: assert property (rd_done && snap_q[5] && !evt[5]
        |=> !flags_q[5])
        else $error("read did not clear flag");
    chk_id_value: assert property ((state_q == ST_ADDR_ACK) && rw_q &&
        scl_fall && (ptr_q == REG_ID) |=> (shift_q == ID_CODE))
        else $error("identity byte wrong");
    chk_set_pin_a_map: assert property ($stable(func2_q) [*2] |->
        (switch_set_pin_a_khz_o == set_pin_a_khz(func2_q[4:3])))
        else $error("frequency decode wrong");
    chk_addr_nak: assert property ((state_q == ST_ADDR) && scl_fall &&
        byte_end && !addr_hit |=> sda_oe_n_o)
        else $error("ack given to a foreign address");
    chk_reset_values: assert property ($rose(!reset_i) |->
        (switch_set_pin_a_select_o == 2'h1 && prot_ctrl_o == PROT_RESET))
        else $error("reset value wrong");

    cov_fault_read: cover property (rd_done && snap_q != 6'h00);
    cov_write_set_pin_a: cover property (wr_en && ptr_q == REG_FUNC2);
    cov_event_on_clear: cover property (rd_done && (snap_q & evt) != 6'h00);

endmodule : fsr_regs

/* testbench/fsr_host_model.sv */
// Purpose: behavioural two-wire bus master for the register bank
// Assumes: data line is open drain, pulled up and resolved by the bench
// Notes:   3-clock phases keep scl high and low above 2 clocks
`timescale 1ns/1ps
module fsr_host_model
    import fsr_pkg::*;
(
    // clock and resolved data line
    input  wire logic clk_sys_i,
    input  wire logic sda_i,
    // bus drive
    output logic      scl_o,
    output logic      sda_low_o
);
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick

    // serves as repeated start too
    task automatic start_cond();
        sda_low_o <= 1'b0;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        sda_low_o <= 1'b1;
        tick(3);
        scl_o <= 1'b0;
        tick(3);
    endtask : start_cond

    task automatic stop_cond();
        sda_low_o <= 1'b1;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        sda_low_o <= 1'b0;
        tick(3);
    endtask : stop_cond

    // data moves only while scl is low
    task automatic bit_io(input logic b, output logic s);
        sda_low_o <= ~b;
        tick(3);
        scl_o <= 1'b1;
        tick(3);
        s = sda_i;
        scl_o <= 1'b0;
        tick(1);
    endtask : bit_io

    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], r[i]);
        end
        bit_io(ack_in, ack);
    endtask : xfer

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                             input logic [7:0] d, output logic [2:0] acks);
        logic [7:0] r;
        start_cond();
        xfer({dev, 1'b0}, 1'b1, r, acks[2]);
        xfer(a, 1'b1, r, acks[1]);
        xfer(d, 1'b1, r, acks[0]);
        stop_cond();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic [2:0] acks);
        logic [7:0] r;
        logic       n;
        start_cond();
        xfer({DEV_ADDR, 1'b0}, 1'b1, r, acks[2]);
        xfer(a, 1'b1, r, acks[1]);
        start_cond();
        xfer({DEV_ADDR, 1'b1}, 1'b1, r, acks[0]);
        xfer(8'hff, 1'b1, d, n);
        stop_cond();
    endtask : read_reg
endmodule : fsr_host_model

/* testbench/fsr_regs_bench.sv */
// Purpose: self-checking bench for the fault / identity register bank
// Assumes: host model phases far slower than the system clock
// Notes:   ordinary cases as table rows, awkward cases after the loop
`timescale 1ns/1ps
module fsr_regs_bench
    import fsr_pkg::*;
;
    typedef struct packed {
        logic [7:0]  wdata;
        logic [11:0] khz;
        fsr_fault_t  evt;
    } fsr_row_t;

    fsr_row_t   rows [6] = '{'{8'h00, FSW_KHZ_200, 6'h20},
                             '{8'h08, FSW_KHZ_400, 6'h10},
                             '{8'h10, FSW_KHZ_1000, 6'h08},
                             '{8'h18, FSW_KHZ_2200, 6'h04},
                             '{8'h27, FSW_KHZ_200, 6'h02},
                             '{8'he8, FSW_KHZ_400, 6'h01}};
    logic       clk_sys_i, reset_i, scl, sda_low, sda_oe_n, sda_drv;
    logic       sda_w;
    fsr_fault_t evt, flags;
    logic [7:0] func1, func2, d;
    logic [1:0] prot, fsel;
    logic [11:0] khz;
    logic [2:0] acks;
    int         n_errors, comparisons, cycles;

    // pull-up: released line reads high
    assign sda_w = ~(sda_low | (~sda_oe_n & ~sda_drv));

    fsr_regs fsr_regs_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_drv),
        .sda_oe_n_o(sda_oe_n), .fault_evt_i(evt), .func1_o(func1),
        .func2_o(func2), .prot_ctrl_o(prot), .switch_set_pin_a_select_o(fsel),
        .switch_set_pin_a_khz_o(khz), .fault_flags_o(flags));
    fsr_host_model fsr_host_model_inst (.clk_sys_i(clk_sys_i),
        .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // run needs about 6200 cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        reset_i = 1'b1;
        evt     = '0;
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("func2", {4'h0, FUNC2_RESET}, {4'h0, func2});
        chk("khz", FSW_KHZ_400, khz);
        chk("flags", 12'(FLAGS_RESET), 12'(flags));
        fsr_host_model_inst.write_reg(DEV_ADDR, REG_ID, 8'ha5, acks);
        fsr_host_model_inst.read_reg(REG_ID, d, acks);
        chk("id", {4'h0, ID_CODE}, {4'h0, d});
        chk("acks", 12'h0, {9'h0, acks});
        fsr_host_model_inst.write_reg(7'h39, REG_FUNC2, 8'h00, acks);
        chk("nak", 12'h7, {9'h0, acks});
        chk("func2", {4'h0, FUNC2_RESET}, {4'h0, func2});
        chk("func1", {4'h0, FUNC1_RESET}, {4'h0, func1});
        foreach (rows[i])
        begin
            // frequency chosen by register only, set/sync pin left open
            fsr_host_model_inst.write_reg(DEV_ADDR, REG_FUNC2,
                                          rows[i].wdata, acks);
            chk("wacks", 12'h0, {9'h0, acks});
            chk("fsel", {10'h0, rows[i].wdata[4:3]}, {10'h0, fsel});
            chk("khz", rows[i].khz, khz);
            fsr_host_model_inst.read_reg(REG_FUNC2, d, acks);
            chk("func2 rd", {4'h0, rows[i].wdata}, {4'h0, d});
            @(posedge clk_sys_i) evt <= rows[i].evt;
            @(posedge clk_sys_i) evt <= '0;
            repeat (3) @(posedge clk_sys_i);
            chk("held", 12'(rows[i].evt),
                12'(flags));
            fsr_host_model_inst.read_reg(REG_FAULT, d, acks);
            chk("fault rd", {6'h0, rows[i].evt},
                {4'h0, d});
            chk("cleared", 12'h0, 12'(flags));
        end
        // event lands after the byte is loaded but before its clear
        @(posedge clk_sys_i) evt <= 6'h01;
        @(posedge clk_sys_i) evt <= '0;
        fork
            fsr_host_model_inst.read_reg(REG_FAULT, d, acks);
            begin
                repeat (240) @(posedge clk_sys_i);
                evt <= 6'h04;
                @(posedge clk_sys_i) evt <= '0;
            end
        join
        chk("race rd", 12'h001, {4'h0, d});
        chk("race kept", 12'h004, 12'(flags));
        fsr_host_model_inst.write_reg(DEV_ADDR, REG_FAULT, 8'hff, acks);
        chk("prot", 12'h3, {10'h0, prot});
        chk("flags ro", 12'h004, 12'(flags));
        fsr_host_model_inst.read_reg(REG_FAULT, d, acks);
        chk("fault rd2", 12'h0c4, {4'h0, d});
        // latch every flag so the mid-run reset has something to clear
        @(posedge clk_sys_i) evt <= 6'h3f;
        @(posedge clk_sys_i) evt <= '0;
        @(posedge clk_sys_i) reset_i <= 1'b1;
        @(posedge clk_sys_i) reset_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("flags rst", 12'h0, 12'(flags));
        chk("prot rst", 12'h0, {10'h0, prot});
        chk("func2 rst", {4'h0, FUNC2_RESET}, {4'h0, func2});
        end_sim();
    end
endmodule : fsr_regs_bench
